// ==== logic/cbx_cfg.svh ====
// Constants for the branch, call and clear execution block
`ifndef CBX_CFG_SVH
`define CBX_CFG_SVH

// Opcode patterns
`define CBX_OP_OVF_BR 8'hE4
`define CBX_OP_ZERO_BR 8'hE0
`define CBX_OP_CALL 7'h76
`define CBX_OP_CALL_EXT 4'hF
`define CBX_OP_CLEAR 7'h35

// Program counter arithmetic
`define CBX_WORD_STEP 21'h000002
`define CBX_RET_STEP 21'h000004
`define CBX_PC_RST 21'h000000

// Data memory addressing
`define CBX_ILO_MAX 8'h5F
`define CBX_ACC_SPLIT 8'h80
`define CBX_ACC_HI_BANK 4'hF
`define CBX_CLEAR_VALUE 8'h00

// Flag bit positions inside the status register
`define CBX_FLAG_Z 2
`define CBX_FLAG_OV 3

// Register word indexes on the bus
`define CBX_REG_CTRL 4'h0
`define CBX_REG_ACCUM 4'h1
`define CBX_REG_FLAGS 4'h2
`define CBX_REG_BANK 4'h3
`define CBX_REG_IDX 4'h4
`define CBX_REG_PC 4'h5
`define CBX_REG_TOS 4'h6
`define CBX_REG_SHADOW 4'h7
`define CBX_REG_STACK 4'h8

// Field positions
`define CBX_CTRL_EXT 0
`define CBX_STACK_FULL 8

// Reset values
`define CBX_RST_BYTE 8'h00
`define CBX_RST_FLAGS 5'h00
`define CBX_RST_BANK 4'h0
`define CBX_RST_IDX 12'h000

`endif

// ==== logic/cbx_exec.sv ====
// Execution of overflow/zero branches, call and clear register
`timescale 1ns/1ps
`include "cbx_cfg.svh"
// Contract
// - Opcode E4 decodes overflow branch, offset low byte
// - Overflow branch taken only with overflow set
// - Zero branch taken only with zero set
// - Target is incremented PC plus twice offset
// - Taken branch: PC at Q4, then flushed cycle
// - Call is two words, 1110110s then 1111 prefix (the code does not check the 1111 prefix of the second word)
// - Call pushes its address plus 4
// - Fast call copies accumulator, flags, bank shadows
// - Normal call leaves shadows unchanged
// - Call loads 20-bit target into PC 20:1
// - Call: push Q3, PC Q4, flushed second cycle
// - Clear writes zero, sets zero flag, one cycle
// - Access bit picks access bank or banked
// - Extended mode low file addresses with access bit clear use indexed offset
module cbx_exec #(
  parameter int STACK_DEPTH = 31,
  parameter int SP_W = 5
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input cbx_pkg::cbx_av_req_t AV_I,
  output logic [31:0] AV_READDATA_O,
  output logic AV_WAITREQUEST_O,
  input wire logic [15:0] PROG_DATA_I,
  output logic [20:0] PROG_ADDR_O,
  output cbx_pkg::cbx_dwr_t DMEM_O,
  output cbx_pkg::cbx_qph_t QPHASE_O
);
  import cbx_pkg::*;

  // Byte-enable merge for software writes
  function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  cbx_qph_t q; // Current quarter phase
  cbx_state_t state; // Execute or flushed cycle
  logic [20:0] pc; // Address of the instruction in execution
  logic [15:0] ir; // Instruction latched at Q1
  logic take; // Branch condition caught at decode
  logic [7:0] accum; // Accumulator
  logic [4:0] flags; // Status register
  logic [3:0] bank; // Bank pointer
  logic [11:0] idx_base; // Base for indexed literal offset
  logic ext_en; // Extended instruction set enable
  logic [7:0] acc_sh; // Accumulator shadow
  logic [4:0] flags_sh; // Flags shadow
  logic [3:0] bank_sh; // Bank pointer shadow
  logic [20:0] stack [STACK_DEPTH]; // Return stack storage
  logic [SP_W-1:0] sp; // Number of entries held
  logic [20:0] return_stack_top; // Return stack top
  logic stk_full; // Push seen with stack full

  // Phase sequencer
  cbx_qphase u_qphase (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .q_o(q)
  );

  // Opcode decode of the fetched word and the latched word
  wire fetch_ovf = PROG_DATA_I[15:8] == `CBX_OP_OVF_BR;
  wire fetch_zero = PROG_DATA_I[15:8] == `CBX_OP_ZERO_BR;
  wire is_ovf = ir[15:8] == `CBX_OP_OVF_BR;
  wire is_zero = ir[15:8] == `CBX_OP_ZERO_BR;
  wire is_call = ir[15:9] == `CBX_OP_CALL;
  wire is_clear = ir[15:9] == `CBX_OP_CLEAR;
  wire call_fast = ir[8];
  wire acc_bit = ir[8];
  wire [7:0] lit = ir[7:0];
  wire exec = state == CBX_ST_EXEC;
  wire at_q1 = q == CBX_Q1;
  wire at_q3 = q == CBX_Q3;
  wire at_q4 = q == CBX_Q4;
  // Phase that follows the current one, mirrored on the output
  cbx_qph_t next_qph;
  assign next_qph = cbx_qph_t'(q + 2'h1);

  // Condition uses the flags as left by the previous instruction
  wire fetch_take = (fetch_ovf && flags[`CBX_FLAG_OV]) ||
      (fetch_zero && flags[`CBX_FLAG_Z]);

  // Next sequential address, branch target and call target
  wire [20:0] pc_seq = pc + `CBX_WORD_STEP;
  wire [20:0] br_off = {{12{lit[7]}}, lit, 1'b0};
  wire [20:0] br_target = pc_seq + br_off;
  wire [20:0] ret_addr = pc + `CBX_RET_STEP;
  wire [20:0] call_target = {PROG_DATA_I[11:0], lit, 1'b0};
  wire br_go = (is_ovf || is_zero) && take;
  wire call_go = is_call;

  // Data address for the clear instruction
  wire use_ilo = ext_en && !acc_bit && lit <= `CBX_ILO_MAX;
  wire [11:0] acc_addr = (lit < `CBX_ACC_SPLIT) ? {4'h0, lit} :
      {`CBX_ACC_HI_BANK, lit};
  wire [11:0] ilo_addr = idx_base + {4'h0, lit};
  wire [11:0] clr_addr = use_ilo ? ilo_addr :
      (acc_bit ? {bank, lit} : acc_addr);

  // Next PC at Q4 of an executed cycle
  wire [20:0] next_pc = br_go ? br_target :
      (call_go ? call_target : pc_seq);

  // Bus decode
  wire av_req = AV_I.read || AV_I.write;
  wire av_acc = av_req && !AV_WAITREQUEST_O;
  wire av_wr = AV_I.write && av_acc;
  wire wr_ctrl = av_wr && AV_I.address == `CBX_REG_CTRL;
  wire wr_accum = av_wr && AV_I.address == `CBX_REG_ACCUM;
  wire wr_flags = av_wr && AV_I.address == `CBX_REG_FLAGS;
  wire wr_bank = av_wr && AV_I.address == `CBX_REG_BANK;
  wire wr_idx = av_wr && AV_I.address == `CBX_REG_IDX;
  wire [31:0] m_ctrl = be_merge({31'h0, ext_en}, AV_I.writedata,
      AV_I.byteenable);
  wire [31:0] m_accum = be_merge({24'h0, accum}, AV_I.writedata,
      AV_I.byteenable);
  wire [31:0] m_flags = be_merge({27'h0, flags}, AV_I.writedata,
      AV_I.byteenable);
  wire [31:0] m_bank = be_merge({28'h0, bank}, AV_I.writedata,
      AV_I.byteenable);
  wire [31:0] m_idx = be_merge({20'h0, idx_base}, AV_I.writedata,
      AV_I.byteenable);

  // Read mux, unmapped words read as zero
  wire [31:0] rd_val =
      (AV_I.address == `CBX_REG_CTRL) ? {31'h0, ext_en} :
      (AV_I.address == `CBX_REG_ACCUM) ? {24'h0, accum} :
      (AV_I.address == `CBX_REG_FLAGS) ? {27'h0, flags} :
      (AV_I.address == `CBX_REG_BANK) ? {28'h0, bank} :
      (AV_I.address == `CBX_REG_IDX) ? {20'h0, idx_base} :
      (AV_I.address == `CBX_REG_PC) ? {11'h0, pc} :
      (AV_I.address == `CBX_REG_TOS) ? {11'h0, return_stack_top} :
      (AV_I.address == `CBX_REG_SHADOW) ?
        {12'h0, bank_sh, 3'h0, flags_sh, acc_sh} :
      (AV_I.address == `CBX_REG_STACK) ?
        {23'h0, stk_full, {(8-SP_W){1'b0}}, sp} : 32'h0;

  // Zero flag set by clear wins over a software write in the same edge
  wire clr_now = exec && at_q4 && is_clear;
  logic [4:0] next_flags;
  always_comb begin
    next_flags = wr_flags ? m_flags[4:0] : flags;
    if (clr_now) begin
      next_flags[`CBX_FLAG_Z] = 1'b1;
    end
  end

  // Bus handshake: one wait cycle, then one accept cycle
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      AV_WAITREQUEST_O <= 1'b1;
      AV_READDATA_O <= 32'h0;
    end else begin
      AV_WAITREQUEST_O <= !(av_req && AV_WAITREQUEST_O);
      if (AV_I.read && AV_WAITREQUEST_O) begin
        AV_READDATA_O <= rd_val;
      end
    end
  end

  // Software-owned registers and the status register
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ext_en <= 1'b0;
      accum <= `CBX_RST_BYTE;
      flags <= `CBX_RST_FLAGS;
      bank <= `CBX_RST_BANK;
      idx_base <= `CBX_RST_IDX;
    end else begin
      if (wr_ctrl) begin
        ext_en <= m_ctrl[`CBX_CTRL_EXT];
      end
      if (wr_accum) begin
        accum <= m_accum[7:0];
      end
      if (wr_bank) begin
        bank <= m_bank[3:0];
      end
      if (wr_idx) begin
        idx_base <= m_idx[11:0];
      end
      flags <= next_flags;
    end
  end

  // Decode latch at Q1: instruction word and branch condition
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ir <= 16'h0000;
      take <= 1'b0;
    end else if (at_q1 && exec) begin
      ir <= PROG_DATA_I;
      take <= fetch_take;
    end
  end

  // Return stack push and shadow copies at Q3 of a call
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sp <= '0;
      return_stack_top <= `CBX_PC_RST;
      stk_full <= 1'b0;
      acc_sh <= `CBX_RST_BYTE;
      flags_sh <= `CBX_RST_FLAGS;
      bank_sh <= `CBX_RST_BANK;
    end else if (exec && at_q3 && is_call) begin
      return_stack_top <= ret_addr;
      if (int'(sp) < STACK_DEPTH) begin
        stack[sp] <= ret_addr;
        sp <= sp + 1'b1;
      end else begin
        stk_full <= 1'b1;
      end
      if (call_fast) begin
        acc_sh <= accum;
        flags_sh <= flags;
        bank_sh <= bank;
      end
    end
  end

  // Program counter, fetch address and cycle state
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pc <= `CBX_PC_RST;
      PROG_ADDR_O <= `CBX_PC_RST;
      state <= CBX_ST_EXEC;
    end else begin
      case (state)
        CBX_ST_EXEC: begin
          if (at_q3 && is_call) begin
            PROG_ADDR_O <= pc_seq;
          end else if (at_q4) begin
            pc <= next_pc;
            PROG_ADDR_O <= next_pc;
            if (br_go || call_go) begin
              state <= CBX_ST_FLUSH;
            end
          end
        end
        default: begin
          if (at_q4) begin
            state <= CBX_ST_EXEC;
          end
        end
      endcase
    end
  end

  // Data memory write of the clear instruction, one pulse at Q4
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      DMEM_O <= '0;
    end else begin
      DMEM_O.we <= clr_now;
      DMEM_O.addr <= clr_addr;
      DMEM_O.data <= `CBX_CLEAR_VALUE;
    end
  end

  // Phase mirror for the fetch path
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      QPHASE_O <= CBX_Q1;
    end else begin
      QPHASE_O <= next_qph;
    end
  end

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_flush;
    (state == CBX_ST_FLUSH) [*4] ##1 (state == CBX_ST_EXEC);
  endsequence

  sequence s_call_q3;
    exec && at_q3 && is_call;
  endsequence

  ovf_decode_a: assert property (
    exec && at_q1 && fetch_ovf |=> is_ovf && lit == $past(PROG_DATA_I[7:0]))
    else $error("overflow branch not decoded");

  ovf_cond_a: assert property (
    exec && at_q1 && fetch_ovf |=> take == $past(flags[`CBX_FLAG_OV]))
    else $error("overflow branch condition wrong");

  zero_cond_a: assert property (
    exec && at_q1 && fetch_zero |=> take == $past(flags[`CBX_FLAG_Z]))
    else $error("zero branch condition wrong");

  br_target_a: assert property (
    exec && at_q4 && br_go |=>
      pc == $past(pc) + `CBX_WORD_STEP + $past(br_off))
    else $error("branch target wrong");

  br_flush_a: assert property (
    exec && at_q4 && br_go |=> s_flush)
    else $error("taken branch not followed by flushed cycle");

  br_skip_a: assert property (
    exec && at_q4 && (is_ovf || is_zero) && !take |=>
      exec && pc == $past(pc) + `CBX_WORD_STEP)
    else $error("untaken branch did not fall through");

  call_push_a: assert property (
    s_call_q3 |=> return_stack_top == $past(pc) + `CBX_RET_STEP)
    else $error("call return address wrong");

  shadow_set_a: assert property (
    (s_call_q3 and call_fast) |=> acc_sh == $past(accum) &&
      flags_sh == $past(flags) && bank_sh == $past(bank))
    else $error("fast call shadow copy wrong");

  shadow_keep_a: assert property (
    (s_call_q3 and !call_fast) |=> $stable(acc_sh) && $stable(flags_sh) &&
      $stable(bank_sh))
    else $error("normal call changed shadows");

  call_pc_a: assert property (
    exec && at_q4 && is_call |=>
      pc == {$past(PROG_DATA_I[11:0]), $past(lit), 1'b0})
    else $error("call target wrong");

  call_seq_a: assert property (
    s_call_q3 ##1 at_q4 |=> s_flush)
    else $error("call cycle sequence wrong");

  clear_write_a: assert property (
    clr_now |=> DMEM_O.we && DMEM_O.data == `CBX_CLEAR_VALUE &&
      flags[`CBX_FLAG_Z] ##1 !DMEM_O.we)
    else $error("clear write or zero flag wrong");

  clear_bank_a: assert property (
    clr_now && acc_bit |=> DMEM_O.addr == {$past(bank), $past(lit)})
    else $error("banked clear address wrong");

  clear_ilo_a: assert property (
    clr_now && use_ilo |=> DMEM_O.addr == $past(idx_base) +
      {4'h0, $past(lit)})
    else $error("indexed clear address wrong");

  br_flags_a: assert property (
    exec && at_q4 && (is_ovf || is_zero) && !wr_flags |=> $stable(flags))
    else $error("branch changed flags");
endmodule // cbx_exec

// ==== logic/cbx_pkg.sv ====
// Types shared by the branch, call and clear execution block
package cbx_pkg;
  // Quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    CBX_Q1 = 2'b00,
    CBX_Q2 = 2'b01,
    CBX_Q3 = 2'b10,
    CBX_Q4 = 2'b11
  } cbx_qph_t;

  // Execute or flushed second cycle
  typedef enum logic {
    CBX_ST_EXEC = 1'b0,
    CBX_ST_FLUSH = 1'b1
  } cbx_state_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } cbx_av_req_t;

  // Data memory write port
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } cbx_dwr_t;
endpackage

// ==== logic/cbx_qphase.sv ====
// Quarter phase sequencer for the instruction cycle
`timescale 1ns/1ps
module cbx_qphase (
  input wire logic clk_i,
  input wire logic reset_i,
  output cbx_pkg::cbx_qph_t q_o
);
  import cbx_pkg::*;

  // Next phase in the fixed Q1..Q4 rotation
  cbx_qph_t next_q;

  always_comb begin
    case (q_o)
      CBX_Q1: next_q = CBX_Q2;
      CBX_Q2: next_q = CBX_Q3;
      CBX_Q3: next_q = CBX_Q4;
      default: next_q = CBX_Q1;
    endcase
  end

  // Phase register, starts at Q1 after reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q_o <= CBX_Q1;
    end else begin
      q_o <= next_q;
    end
  end
endmodule // cbx_qphase

// ==== verification/cbx_exec_tb.sv ====
// Self-checking bench for the branch, call and clear block
`timescale 1ns/1ps
`include "cbx_cfg.svh"
module cbx_exec_tb;
  import cbx_pkg::*;
  logic CLK_I = 1'b0; // Core clock
  logic RESET_I = 1'b1; // Asynchronous reset
  cbx_av_req_t av = '0; // Bus request
  logic [31:0] rdata; // Bus read data
  logic wait_req; // Bus stall
  logic [15:0] pdata; // Program word
  logic [20:0] paddr; // Fetch address
  cbx_dwr_t dwr; // Data write port
  cbx_qph_t qph; // Quarter phase
  logic [31:0] rv; // Last read value
  int fails = 0; // Mismatches
  int cmp_count = 0; // Comparisons
  // Branch cases: opcode, flags, offset, next address, its span
  localparam logic [7:0] br_op [4] = '{8'hE4, 8'hE4, 8'hE0, 8'hE0};
  localparam logic [4:0] br_fl [4] = '{5'h08, 5'h17, 5'h04, 5'h1B};
  localparam logic [7:0] br_off [4] = '{8'h7F, 8'h80, 8'h80, 8'h7F};
  localparam logic [20:0] br_tgt [4] = '{21'h200, 21'h102, 21'h002,
    21'h102};
  localparam int br_sp [4] = '{8, 4, 8, 4};
  // Expected data writes of the clear sequence
  localparam logic [19:0] cl_exp [4] = '{20'h32200, 20'h25F00,
    20'h06000, 20'hF8000};

  // Half period of 2.5 ns
  always #2.5 CLK_I = ~CLK_I;

  cbx_exec uut (
    .CLK_I(CLK_I),
    .RESET_I(RESET_I),
    .AV_I(av),
    .AV_READDATA_O(rdata),
    .AV_WAITREQUEST_O(wait_req),
    .PROG_DATA_I(pdata),
    .PROG_ADDR_O(paddr),
    .DMEM_O(dwr),
    .QPHASE_O(qph)
  );

  cbx_mem_model pm (
    .clk_i(CLK_I),
    .addr_i(paddr),
    .data_o(pdata),
    .dwr_i(dwr)
  );

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic r, input logic [3:0] a,
      input logic [31:0] wd);
    @(posedge CLK_I);
    av <= '{r, ~r, a, 4'hF, wd};
    // No cycle limit here: a hung slave is caught by the watchdog
    do begin
      @(posedge CLK_I);
    end while (wait_req !== 1'b0);
    rv = rdata;
    av <= '0;
  endtask

  // Register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  // Register read against an expected value
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b1, a, 32'h0);
    check(rv, exp);
  endtask

  // Reset for three cycles with an empty program
  task automatic boot();
    RESET_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    pm.clear_all();
    RESET_I <= 1'b0;
  endtask

  // Wait until the fetch address shows p
  task automatic wait_at(input logic [20:0] p);
    int n;
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
    end while (paddr !== p && n < 3000);
    check(32'(paddr), 32'(p));
    check(32'(qph), 32'(CBX_Q1));
  endtask

  // Fetch address is ea and stands ec clocks
  task automatic span(input logic [20:0] ea, input int ec);
    int n;
    n = 0;
    check(32'(paddr), 32'(ea));
    do begin
      @(posedge CLK_I);
      n++;
    end while (paddr === ea && n < 40);
    check(n, ec);
  endtask

  // Main sequence
  initial begin
    boot();
    // Reset values, unmapped and read-only words
    for (int i = 0; i < 9; i++) begin
      if (i != 5) begin
        rd(4'(i), 32'h0);
      end
    end
    wr(4'hF, 32'h5A);
    rd(4'hF, 32'h0);
    wr(`CBX_REG_TOS, 32'h123);
    rd(`CBX_REG_TOS, 32'h0);
    // Conditional branches, taken and not, at both offset limits
    for (int i = 0; i < 4; i++) begin
      boot();
      pm.mem[13'h80] = {br_op[i], br_off[i]};
      wr(`CBX_REG_FLAGS, {27'h0, br_fl[i]});
      wait_at(21'h100);
      span(21'h100, 4);
      span(br_tgt[i], br_sp[i]);
      rd(`CBX_REG_FLAGS, {27'h0, br_fl[i]});
    end
    // Fast call followed by a normal call
    boot();
    pm.mem[13'h80] = 16'hED34;
    pm.mem[13'h81] = 16'hF012;
    pm.mem[13'h1240] = 16'hEC56;
    pm.mem[13'h1241] = 16'hF00A;
    wr(`CBX_REG_ACCUM, 32'hA5);
    wr(`CBX_REG_FLAGS, 32'h15);
    wr(`CBX_REG_BANK, 32'h9);
    wait_at(21'h100);
    span(21'h100, 3);
    span(21'h102, 1);
    span(21'h2468, 8);
    rd(`CBX_REG_TOS, 32'h104);
    rd(`CBX_REG_SHADOW, 32'h000915A5);
    rd(`CBX_REG_STACK, 32'h1);
    wr(`CBX_REG_ACCUM, 32'h3C);
    wait_at(21'h2480);
    span(21'h2480, 3);
    span(21'h2482, 1);
    span(21'h014AC, 8);
    rd(`CBX_REG_TOS, 32'h2484);
    rd(`CBX_REG_SHADOW, 32'h000915A5);
    rd(`CBX_REG_STACK, 32'h2);
    // Clears: banked, indexed, access bank low and high
    boot();
    pm.mem[13'h80] = 16'h6B22;
    pm.mem[13'h81] = 16'h6A5F;
    pm.mem[13'h82] = 16'h6A60;
    pm.mem[13'h83] = 16'h6A80;
    wr(`CBX_REG_CTRL, 32'h1);
    wr(`CBX_REG_IDX, 32'h200);
    wr(`CBX_REG_BANK, 32'h3);
    wr(`CBX_REG_FLAGS, 32'h08);
    wait_at(21'h100);
    span(21'h100, 4);
    span(21'h102, 4);
    wait_at(21'h10A);
    check(pm.wlog.size(), 4);
    for (int i = 0; i < 4; i++) begin
      check(32'(pm.wlog[i]), 32'(cl_exp[i]));
    end
    rd(`CBX_REG_FLAGS, 32'h0C);
    close_out();
  end

  // Watchdog well past the expected run length
  initial begin
    #40000;
    fails++;
    close_out();
  end
endmodule // cbx_exec_tb

// ==== verification/cbx_mem_model.sv ====
// Program memory and data write log beside the execution block
`timescale 1ns/1ps
module cbx_mem_model (
  input wire logic clk_i,
  input wire logic [20:0] addr_i,
  output logic [15:0] data_o,
  input cbx_pkg::cbx_dwr_t dwr_i
);
  import cbx_pkg::*;
  logic [15:0] mem [0:8191]; // Program words, byte address bits 13:1
  logic [19:0] wlog [$]; // Data writes as address then value

  // Words past the array read as an unused opcode
  assign data_o = (addr_i < 21'h004000) ? mem[addr_i[13:1]] : 16'hFFFF;

  // Empty program and write log
  function automatic void clear_all();
    foreach (mem[i]) begin
      mem[i] = 16'hFFFF;
    end
    wlog.delete();
  endfunction

  // Start with an empty program
  initial begin
    clear_all();
  end

  // Log each write strobe seen at the clock edge
  always @(posedge clk_i) begin
    if (dwr_i.we === 1'b1) begin
      wlog.push_back({dwr_i.addr, dwr_i.data});
    end
  end
endmodule // cbx_mem_model
